// File: logic/dcw_decoder.sv
/*
 * Drive control word decoder: takes the cyclic control word and speed setpoint
 * from the fieldbus master and turns them into drive state, pulse enable,
 * ramp generator, motor potentiometer and command data set controls.
 * Assumes the fieldbus interface delivers each received word with a one-cycle
 * strobe synchronous to mclk, and the telegram selection is a stable level.
 */
`timescale 1ns/1ns

module dcw_decoder #(
	parameter int W = 16,
	parameter logic [3:0] FREE_RX_WORDS = 4'h2,
	parameter logic [3:0] FREE_TX_WORDS = 4'h2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Cyclic process data from the fieldbus master
	input wire logic [15:0] drive_control_word,
	input wire logic control_word_strobe,
	input wire logic [W-1:0] speed_setpoint,
	input wire logic setpoint_strobe,
	// Drive configuration and feedback
	input wire logic [9:0] telegram_sel,
	input wire logic fault_active,
	input wire logic [W-1:0] ramp_up_step,
	input wire logic [W-1:0] ramp_down_step,
	input wire logic [W-1:0] fast_stop_step,
	// Drive state and commands
	output logic [2:0] drive_state_q,
	output logic pulse_enable_q,
	output logic closing_lockout_q,
	output logic fault_ack_q,
	output logic master_control_q,
	output logic command_data_set_q,
	output logic setpoint_invert_q,
	// Setpoint paths
	output logic signed [W-1:0] ramp_generator_q,
	output logic signed [W-1:0] motor_potentiometer_q,
	// Process word layout
	output logic [3:0] rx_words_q,
	output logic [3:0] tx_words_q,
	output logic double_word_ok_q
);
	typedef struct packed {
		dcw_pkg::dcw_state_e state;
		logic [15:0] cw;
		logic [W-1:0] setp;
		logic on_rise;
		logic ack_rise;
		logic fault_ack;
		logic legacy;
		logic command_data_set;
		logic [3:0] rx_words;
		logic [3:0] tx_words;
		logic dword_ok;
	} dcw_dec_s;

	dcw_dec_s s_q;
	dcw_dec_s s_d;

	logic bit_on;
	logic bit_no_coast;
	logic bit_no_fast;
	logic bit_enable;
	logic ramp_zero;
	logic ramp_freeze;
	logic is_tg20;
	logic dev_bits;
	logic running;
	logic standstill;
	logic signed [W-1:0] ramp_target;
	logic [W-1:0] ramp_step;

	// Word counts per telegram: rx in the upper nibble, tx in the lower
	function automatic logic [7:0] tg_words(input logic [9:0] tg);
		case (tg)
			dcw_pkg::TG_STD20: tg_words = {dcw_pkg::WORDS_2, dcw_pkg::WORDS_6};
			dcw_pkg::TG_352, dcw_pkg::TG_354: tg_words = {dcw_pkg::WORDS_6, dcw_pkg::WORDS_6};
			dcw_pkg::TG_FREE: tg_words = {FREE_RX_WORDS, FREE_TX_WORDS};
			default: tg_words = {dcw_pkg::WORDS_2, dcw_pkg::WORDS_2};
		endcase
	endfunction : tg_words

	// Level decodes of the accepted word; masked bits never reach logic
	assign bit_on = s_q.cw[dcw_pkg::CW_ON];
	assign bit_no_coast = s_q.cw[dcw_pkg::CW_NO_COAST];
	assign bit_no_fast = s_q.cw[dcw_pkg::CW_NO_FAST];
	assign bit_enable = s_q.cw[dcw_pkg::CW_ENABLE_OP];
	assign is_tg20 = (telegram_sel == dcw_pkg::TG_STD20);
	// Device-specific bits 11, 13, 14 live on in telegram 20 only if inherited
	assign dev_bits = !is_tg20 || s_q.legacy;
	assign running = (s_q.state == dcw_pkg::DCW_OPERATE);
	assign standstill = (ramp_generator_q == '0);

	// Ramp control: zeroed whenever pulses are off, so restart begins at rest
	assign ramp_zero = !running && s_q.state != dcw_pkg::DCW_RAMP_STOP
		&& s_q.state != dcw_pkg::DCW_FAST_STOP
		|| !s_q.cw[dcw_pkg::CW_RAMP_KEEP];
	assign ramp_freeze = running && !s_q.cw[dcw_pkg::CW_RAMP_RUN];

	// Ramp target and slope per state
	always_comb begin
		ramp_target = '0;
		ramp_step = ramp_down_step;
		if (s_q.state == dcw_pkg::DCW_FAST_STOP) begin
			ramp_step = fast_stop_step;
		end else if (running && s_q.cw[dcw_pkg::CW_SETP_EN]) begin
			ramp_step = ramp_up_step;
			if (dev_bits && s_q.cw[dcw_pkg::CW_INVERT]) begin
				ramp_target = -$signed(s_q.setp);
			end else begin
				ramp_target = $signed(s_q.setp);
			end
		end
		// Otherwise brake to zero on the normal ramp-down slope
	end

	// Next state
	always_comb begin
		logic [15:0] word;
		logic [7:0] words;
		word = drive_control_word & dcw_pkg::CW_USED_MASK;
		words = tg_words(telegram_sel);
		s_d = s_q;
		s_d.on_rise = 1'b0;
		s_d.ack_rise = 1'b0;
		s_d.fault_ack = 1'b0;
		s_d.rx_words = words[7:4];
		s_d.tx_words = words[3:0];
		s_d.dword_ok = (telegram_sel == dcw_pkg::TG_FREE);
		if (!is_tg20) begin
			s_d.legacy = 1'b1;
		end
		// Accept data only while the master claims control; else keep the old word
		if (control_word_strobe && word[dcw_pkg::CW_MASTER]) begin
			s_d.cw = word;
			s_d.on_rise = word[dcw_pkg::CW_ON] && !s_q.cw[dcw_pkg::CW_ON];
			s_d.ack_rise = word[dcw_pkg::CW_FAULT_ACK] && !s_q.cw[dcw_pkg::CW_FAULT_ACK];
			if (is_tg20) begin
				s_d.command_data_set = word[dcw_pkg::CW_CDS0];
			end
		end
		if (setpoint_strobe && s_q.cw[dcw_pkg::CW_MASTER]) begin
			s_d.setp = speed_setpoint;
		end
		if (s_q.ack_rise) begin
			s_d.fault_ack = 1'b1;
		end
		// Drive state machine; coast and fault win over everything
		if (fault_active || !bit_no_coast) begin
			s_d.state = dcw_pkg::DCW_LOCKOUT;
		end else begin
			unique case (s_q.state)
				dcw_pkg::DCW_LOCKOUT: begin
					// Leave lockout only after ON is seen low with no stop pending
					if (!bit_on && bit_no_fast && !s_q.ack_rise) begin
						s_d.state = dcw_pkg::DCW_READY_START;
					end
				end
				dcw_pkg::DCW_READY_START: begin
					if (s_q.ack_rise && bit_on) begin
						s_d.state = dcw_pkg::DCW_LOCKOUT;
					end else if (s_q.on_rise && bit_no_fast) begin
						s_d.state = dcw_pkg::DCW_READY;
					end
				end
				dcw_pkg::DCW_READY: begin
					if (!bit_no_fast) begin
						s_d.state = dcw_pkg::DCW_LOCKOUT;
					end else if (!bit_on) begin
						s_d.state = dcw_pkg::DCW_READY_START;
					end else if (bit_enable) begin
						s_d.state = dcw_pkg::DCW_OPERATE;
					end
				end
				dcw_pkg::DCW_OPERATE: begin
					if (!bit_no_fast) begin
						s_d.state = dcw_pkg::DCW_FAST_STOP;
					end else if (!bit_enable) begin
						s_d.state = dcw_pkg::DCW_READY;
					end else if (!bit_on) begin
						s_d.state = dcw_pkg::DCW_RAMP_STOP;
					end
				end
				dcw_pkg::DCW_RAMP_STOP: begin
					if (!bit_no_fast) begin
						s_d.state = dcw_pkg::DCW_FAST_STOP;
					end else if (!bit_enable) begin
						s_d.state = dcw_pkg::DCW_READY_START;
					end else if (bit_on && s_q.on_rise) begin
						s_d.state = dcw_pkg::DCW_OPERATE;
					end else if (standstill) begin
						s_d.state = dcw_pkg::DCW_READY_START;
					end
				end
				dcw_pkg::DCW_FAST_STOP: begin
					// Quick stop always ends in lockout, even if bit 2 returns
					if (!bit_enable || standstill) begin
						s_d.state = dcw_pkg::DCW_LOCKOUT;
					end
				end
				default: s_d.state = dcw_pkg::DCW_LOCKOUT;
			endcase
		end
	end

	// State register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_q.state <= dcw_pkg::DCW_LOCKOUT;
			s_q.cw <= dcw_pkg::CW_RESET;
			s_q.setp <= dcw_pkg::SETP_RESET;
			s_q.on_rise <= 1'b0;
			s_q.ack_rise <= 1'b0;
			s_q.fault_ack <= 1'b0;
			s_q.legacy <= 1'b0;
			s_q.command_data_set <= 1'b0;
			s_q.rx_words <= dcw_pkg::WORDS_2;
			s_q.tx_words <= dcw_pkg::WORDS_2;
			s_q.dword_ok <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// Ramp generator on the accepted setpoint
	dcw_ramp_gen #(
		.W(W)
	) u_ramp (
		.mclk(mclk),
		.resetn(resetn),
		.target(ramp_target),
		.step(ramp_step),
		.force_zero(ramp_zero),
		.freeze(ramp_freeze),
		.value_q(ramp_generator_q)
	);

	// Motor potentiometer steered by bits 13 and 14
	dcw_motor_pot #(
		.W(W)
	) u_pot (
		.mclk(mclk),
		.resetn(resetn),
		.up(dev_bits && s_q.cw[dcw_pkg::CW_POT_UP]),
		.down(dev_bits && s_q.cw[dcw_pkg::CW_POT_DOWN]),
		.value_q(motor_potentiometer_q)
	);

	// Outputs straight from the state register, except setpoint_invert_q, which also decodes the live telegram_sel
	assign drive_state_q = s_q.state;
	assign pulse_enable_q = (s_q.state == dcw_pkg::DCW_OPERATE) || (s_q.state == dcw_pkg::DCW_RAMP_STOP)
		|| (s_q.state == dcw_pkg::DCW_FAST_STOP);
	assign closing_lockout_q = (s_q.state == dcw_pkg::DCW_LOCKOUT);
	assign fault_ack_q = s_q.fault_ack;
	assign master_control_q = s_q.cw[dcw_pkg::CW_MASTER];
	assign command_data_set_q = s_q.command_data_set;
	assign setpoint_invert_q = dev_bits && s_q.cw[dcw_pkg::CW_INVERT];
	assign rx_words_q = s_q.rx_words;
	assign tx_words_q = s_q.tx_words;
	assign double_word_ok_q = s_q.dword_ok;
endmodule : dcw_decoder

// File: logic/dcw_motor_pot.sv
/*
 * Motor potentiometer: a stored setpoint that steps up or down once per tick
 * while its up or down command is held.
 * Assumes up and down are levels from the decoded control word.
 */
`timescale 1ns/1ns
module dcw_motor_pot #(
	parameter int W = 16,
	parameter int TICK = dcw_pkg::POT_TICK_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Commands
	input wire logic up,
	input wire logic down,
	// Stored setpoint
	output logic signed [W-1:0] value_q
);
	localparam logic signed [W-1:0] VMAX = {1'b0, {(W-1){1'b1}}};
	localparam logic signed [W-1:0] VMIN = -VMAX;
	// A one-bit signed literal reads as minus one, so the unit step is spelt out at full width
	localparam logic signed [W-1:0] VONE = {{(W-1){1'b0}}, 1'b1};

	typedef struct packed {
		logic signed [W-1:0] value;
		logic [15:0] tick;
	} dcw_mp_s;

	dcw_mp_s s_q;
	dcw_mp_s s_d;

	// Both commands at once cancel; limits stop the count from wrapping
	always_comb begin
		s_d = s_q;
		if (up == down) begin
			s_d.tick = '0;
		end else if (s_q.tick == 16'(TICK - 1)) begin
			s_d.tick = '0;
			if (up && s_q.value != VMAX) begin
				s_d.value = s_q.value + VONE;
			end else if (down && s_q.value != VMIN) begin
				s_d.value = s_q.value - VONE;
			end
		end else begin
			s_d.tick = s_q.tick + 16'h0001;
		end
	end

	// State register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign value_q = s_q.value;
endmodule : dcw_motor_pot

// File: logic/dcw_pkg.sv
/*
 * Constants of the drive control word decoder: bit positions of the control word,
 * telegram codes, process word counts, reset values and timing counts.
 * Assumes a single 50 MHz clock (mclk) and an active-low asynchronous reset.
 */
package dcw_pkg;
	// Control word bit positions
	localparam int CW_ON = 0;
	localparam int CW_NO_COAST = 1;
	localparam int CW_NO_FAST = 2;
	localparam int CW_ENABLE_OP = 3;
	localparam int CW_RAMP_KEEP = 4;
	localparam int CW_RAMP_RUN = 5;
	localparam int CW_SETP_EN = 6;
	localparam int CW_FAULT_ACK = 7;
	localparam int CW_MASTER = 10;
	localparam int CW_INVERT = 11;
	localparam int CW_POT_UP = 13;
	localparam int CW_POT_DOWN = 14;
	localparam int CW_CDS0 = 15;
	// Bits that carry a meaning; 8, 9 and 12 are masked out
	localparam logic [15:0] CW_USED_MASK = 16'hECFF;
	// Telegram selection codes
	localparam logic [9:0] TG_STD1 = 10'h001;
	localparam logic [9:0] TG_STD20 = 10'h014;
	localparam logic [9:0] TG_352 = 10'h160;
	localparam logic [9:0] TG_353 = 10'h161;
	localparam logic [9:0] TG_354 = 10'h162;
	localparam logic [9:0] TG_FREE = 10'h3E7;
	// Process word counts per telegram
	localparam logic [3:0] WORDS_2 = 4'h2;
	localparam logic [3:0] WORDS_6 = 4'h6;
	// Reset values
	localparam logic [15:0] CW_RESET = 16'h0000;
	localparam logic [15:0] SETP_RESET = 16'h0000;
	localparam logic [9:0] TG_RESET = TG_STD1;
	// Motor potentiometer step interval
	localparam int CLK_MHZ = 50;
	localparam int POT_TICK_US = 10;
	localparam int POT_TICK_CYC = POT_TICK_US * CLK_MHZ;
	// Drive states, Gray coded along the switch-on and stop path
	typedef enum logic [2:0] {
		DCW_LOCKOUT = 3'b000,
		DCW_READY_START = 3'b001,
		DCW_READY = 3'b011,
		DCW_OPERATE = 3'b010,
		DCW_RAMP_STOP = 3'b110,
		DCW_FAST_STOP = 3'b111
	} dcw_state_e;
endpackage : dcw_pkg

// File: logic/dcw_ramp_gen.sv
/*
 * Ramp generator: moves its output toward a target by a step per clock,
 * can be forced to zero or frozen.
 * Assumes step values are set by the caller and are stable while ramping.
 */
`timescale 1ns/1ns
module dcw_ramp_gen #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Control
	input wire logic signed [W-1:0] target,
	input wire logic [W-1:0] step,
	input wire logic force_zero,
	input wire logic freeze,
	// Output
	output logic signed [W-1:0] value_q
);
	typedef struct packed {
		logic signed [W-1:0] value;
	} dcw_rg_s;

	dcw_rg_s s_q;
	dcw_rg_s s_d;

	// Step toward the target; clamp so the output never overshoots
	always_comb begin
		logic signed [W:0] diff;
		diff = {target[W-1], target} - {s_q.value[W-1], s_q.value};
		s_d = s_q;
		if (force_zero) begin
			s_d.value = '0;
		end else if (!freeze) begin
			if (diff > $signed({1'b0, step})) begin
				s_d.value = s_q.value + $signed(step);
			end else if (diff < -$signed({1'b0, step})) begin
				s_d.value = s_q.value - $signed(step);
			end else begin
				s_d.value = target;
			end
		end
	end

	// State register
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign value_q = s_q.value;
endmodule : dcw_ramp_gen

// File: testbench/dcw_decoder_assertions.sv
/* Port checker for the control word decoder.
   Assumes a bind to dcw_decoder; it only watches the decoder ports. */
`timescale 1ns/1ns
module dcw_decoder_chk #(
	parameter int W = 16
) (
	// Clock, reset and inputs
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [15:0] drive_control_word,
	input wire logic control_word_strobe,
	input wire logic [9:0] telegram_sel,
	// Decoder outputs
	input wire logic [2:0] drive_state_q,
	input wire logic pulse_enable_q,
	input wire logic fault_ack_q,
	input wire logic master_control_q,
	input wire logic command_data_set_q,
	input wire logic signed [W-1:0] ramp_generator_q,
	input wire logic signed [W-1:0] motor_potentiometer_q,
	input wire logic [3:0] rx_words_q,
	input wire logic [3:0] tx_words_q,
	input wire logic double_word_ok_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// A word counts only with master control requested in it
	wire take = control_word_strobe && drive_control_word[10];

	property p_refuse;
		control_word_strobe && !drive_control_word[10] |=> $stable(master_control_q);
	endproperty
	a_refuse: assert property (p_refuse) else $error("refused word took effect");
	property p_accept;
		take |=> master_control_q;
	endproperty
	a_accept: assert property (p_accept) else $error("accepted word not taken");
	property p_pulse;
		pulse_enable_q == (drive_state_q inside {3'b010, 3'b110, 3'b111});
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse enable off state");
	property p_ack;
		fault_ack_q |=> !fault_ack_q;
	endproperty
	a_ack: assert property (p_ack) else $error("ack pulse too long");
	property p_coast;
		take && !drive_control_word[1] |-> ##[2:3] drive_state_q == 3'b000;
	endproperty
	a_coast: assert property (p_coast) else $error("coast stop missed");
	property p_zero;
		take && !drive_control_word[4] |-> ##[1:4] ramp_generator_q == 0;
	endproperty
	a_zero: assert property (p_zero) else $error("ramp not forced to zero");
	property p_words;
		($stable(telegram_sel))[*2] ##0 telegram_sel inside {10'h001, 10'h014}
			|-> rx_words_q == 4'h2 && tx_words_q == (telegram_sel == 10'h014 ? 4'h6 : 4'h2);
	endproperty
	a_words: assert property (p_words) else $error("word counts wrong");
	property p_dword;
		($stable(telegram_sel))[*2] |-> double_word_ok_q == (telegram_sel == 10'h3E7);
	endproperty
	a_dword: assert property (p_dword) else $error("double word flag wrong");
	property p_pot;
		!$stable(motor_potentiometer_q) |-> motor_potentiometer_q - $past(motor_potentiometer_q) == 1
			|| $past(motor_potentiometer_q) - motor_potentiometer_q == 1;
	endproperty
	a_pot: assert property (p_pot) else $error("pot step not one");
	property p_cds;
		!$stable(command_data_set_q) |-> $past(telegram_sel) == 10'h014;
	endproperty
	a_cds: assert property (p_cds) else $error("command set moved off telegram 20");
endmodule : dcw_decoder_chk

bind dcw_decoder dcw_decoder_chk #(.W(W)) i_dcw_decoder_chk (.mclk, .resetn, .drive_control_word,
	.control_word_strobe, .telegram_sel, .drive_state_q, .pulse_enable_q, .fault_ack_q, .master_control_q,
	.command_data_set_q, .ramp_generator_q, .motor_potentiometer_q, .rx_words_q, .tx_words_q, .double_word_ok_q);

// File: testbench/dcw_decoder_test.sv
/* Bench for the control word decoder: the master model sends words and each drive step is checked.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/1ns
module dcw_decoder_test;
	// Inputs and outputs of the decoder
	logic mclk, resetn, fault_active, control_word_strobe, setpoint_strobe;
	logic [15:0] drive_control_word, speed_setpoint, ramp_up_step, ramp_down_step, fast_stop_step;
	logic [9:0] telegram_sel;
	logic [2:0] drive_state_q;
	logic pulse_enable_q, closing_lockout_q, fault_ack_q, master_control_q, command_data_set_q, setpoint_invert_q;
	logic signed [15:0] ramp_generator_q, motor_potentiometer_q, pot;
	logic [3:0] rx_words_q, tx_words_q;
	logic double_word_ok_q;
	int num_errors, compares, seen;

	dcw_plc_model i_dcw_plc_model (.mclk, .drive_control_word, .control_word_strobe, .speed_setpoint,
		.setpoint_strobe);
	dcw_decoder i_dcw_decoder (.mclk, .resetn, .drive_control_word, .control_word_strobe, .speed_setpoint,
		.setpoint_strobe, .telegram_sel, .fault_active, .ramp_up_step, .ramp_down_step, .fast_stop_step,
		.drive_state_q, .pulse_enable_q, .closing_lockout_q, .fault_ack_q, .master_control_q, .command_data_set_q,
		.setpoint_invert_q, .ramp_generator_q, .motor_potentiometer_q, .rx_words_q, .tx_words_q, .double_word_ok_q);

	// 50 MHz clock
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Shared helpers: cycles, compares, bounded waits
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	function automatic logic [15:0] pick(input int sel);
		return sel == 0 ? {13'h0000, drive_state_q} : ramp_generator_q;
	endfunction : pick
	task automatic wait_for(input int sel, input logic [15:0] exp);
		int n;
		n = 0;
		while (pick(sel) !== exp && n < 3000) begin
			tick(1);
			n++;
		end
		check(pick(sel), exp);
	endtask : wait_for
	task automatic cw(input logic [15:0] w);
		i_dcw_plc_model.send_cw(w, 1'b0);
	endtask : cw
	task automatic results();
		$display("Errors %0d, compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	// A hang ends the run as a failure
	initial begin
		#500000;
		num_errors++;
		$display("BAD at %0t: timeout", $time);
		results();
	end
	// Main sequence
	initial begin
		resetn = 1'b0;
		fault_active = 1'b0;
		telegram_sel = 10'h001;
		ramp_up_step = 16'h000A;
		ramp_down_step = 16'h0005;
		fast_stop_step = 16'h0014;
		tick(3);
		resetn = 1'b1;
		check({rx_words_q, tx_words_q, 4'h0, closing_lockout_q, drive_state_q}, 16'h2208);
		cw(16'h000F);
		tick(4);
		check({12'h000, master_control_q, drive_state_q}, 16'h0000);
		cw(16'h0406);
		wait_for(0, 16'h0001);
		check({15'h0000, master_control_q}, 16'h0001);
		cw(16'h047F);
		i_dcw_plc_model.send_sp(16'h0064);
		wait_for(0, 16'h0002);
		wait_for(1, 16'h0064);
		cw(16'h045F);
		i_dcw_plc_model.send_sp(16'h0028);
		tick(20);
		check(ramp_generator_q, 16'h0064);
		cw(16'h047E);
		wait_for(0, 16'h0001);
		check(ramp_generator_q, 16'h0000);
		cw(16'h047F);
		wait_for(1, 16'h0028);
		cw(16'h046F);
		tick(4);
		check(ramp_generator_q, 16'h0000);
		cw(16'h0477);
		wait_for(0, 16'h0003);
		check({15'h0000, pulse_enable_q}, 16'h0000);
		cw(16'h0475);
		wait_for(0, 16'h0000);
		i_dcw_plc_model.send_cw(16'h1706, 1'b1);
		wait_for(0, 16'h0001);
		cw(16'h0486);
		seen = 0;
		repeat (5) begin
			tick(1);
			seen = seen | fault_ack_q;
		end
		check(seen[15:0], 16'h0001);
		cw(16'h047F);
		wait_for(1, 16'h0028);
		cw(16'h047B);
		wait_for(0, 16'h0000);
		check(ramp_generator_q, 16'h0000);
		cw(16'h2406);
		tick(2250);
		pot = motor_potentiometer_q;
		check({15'h0000, pot >= 4 && pot <= 5}, 16'h0001);
		cw(16'h4406);
		tick(1250);
		check({15'h0000, motor_potentiometer_q <= pot - 2}, 16'h0001);
		cw(16'h0C06);
		tick(3);
		check({15'h0000, setpoint_invert_q}, 16'h0001);
		telegram_sel = 10'h014;
		tick(3);
		check({rx_words_q, tx_words_q, 8'h00}, 16'h2600);
		cw(16'h8406);
		tick(3);
		check({14'h0000, command_data_set_q, setpoint_invert_q}, 16'h0002);
		telegram_sel = 10'h3E7;
		tick(3);
		check({15'h0000, double_word_ok_q}, 16'h0001);
		results();
	end
endmodule : dcw_decoder_test

// File: testbench/dcw_plc_model.sv
/* Fieldbus master model: writes control words and setpoints as single words.
   Assumes the bench calls its tasks from one process only. */
`timescale 1ns/1ns
module dcw_plc_model (
	// Clock
	input wire logic mclk,
	// Cyclic process data
	output logic [15:0] drive_control_word,
	output logic control_word_strobe,
	output logic [15:0] speed_setpoint,
	output logic setpoint_strobe
);
	// Idle lines at time zero
	initial begin
		drive_control_word = 16'h0000;
		control_word_strobe = 1'b0;
		speed_setpoint = 16'h0000;
		setpoint_strobe = 1'b0;
	end
	// Data is inverted once the strobe drops so a stale word is never mistaken for a new one
	task automatic send_cw(input logic [15:0] w, input logic raw);
		@(posedge mclk);
		#1;
		drive_control_word = raw ? w : (w & 16'hECFF);
		control_word_strobe = 1'b1;
		@(posedge mclk);
		#1;
		control_word_strobe = 1'b0;
		drive_control_word = ~drive_control_word;
	endtask : send_cw
	// Setpoint word, same framing
	task automatic send_sp(input logic [15:0] v);
		@(posedge mclk);
		#1;
		speed_setpoint = v;
		setpoint_strobe = 1'b1;
		@(posedge mclk);
		#1;
		setpoint_strobe = 1'b0;
		speed_setpoint = ~v;
	endtask : send_sp
endmodule : dcw_plc_model
